//--- uqes_pkg.sv
// Package for the request tracking queue event sources.
// Assumes one uncore clock; event and unit mask codes are 8 bits.
`default_nettype none

package uqes_pkg;
  // ----------------------------------------------------------------------
  // Event numbers
  // ----------------------------------------------------------------------
  localparam logic [7:0] EV_OCCUPANCY = 8'h02;
  localparam logic [7:0] EV_ALLOC = 8'h03;
  localparam logic [7:0] EV_DATA_IN = 8'h04;
  localparam logic [7:0] EV_DATA_OUT = 8'h05;
  localparam logic [7:0] EV_SNP_LOCAL = 8'h06;
  // ----------------------------------------------------------------------
  // Unit masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] UM_OCC_READ = 8'h01;
  localparam logic [7:0] UM_ALLOC_READ = 8'h01;
  localparam logic [7:0] UM_ALLOC_RD_MISS = 8'h02;
  localparam logic [7:0] UM_ALLOC_RD_RESP = 8'h04;
  localparam logic [7:0] UM_ALLOC_RD_TID = 8'h08;
  localparam logic [7:0] UM_ALLOC_WR_TID = 8'h10;
  localparam logic [7:0] UM_ALLOC_WR_MISS = 8'h20;
  localparam logic [7:0] UM_ALLOC_PROBE = 8'h40;
  localparam logic [7:0] UM_IN_SYSLINK = 8'h01;
  localparam logic [7:0] UM_IN_MCLINK = 8'h02;
  localparam logic [7:0] UM_IN_LLC = 8'h04;
  localparam logic [7:0] UM_IN_CORES02 = 8'h08;
  localparam logic [7:0] UM_IN_CORES13 = 8'h10;
  localparam logic [7:0] UM_OUT_LINKS = 8'h01;
  localparam logic [7:0] UM_OUT_LLC = 8'h02;
  localparam logic [7:0] UM_OUT_CORES = 8'h04;
  localparam logic [7:0] UM_SNP_ABSENT = 8'h01;
  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int RT_ENTRIES = 32;
  localparam int OCC_W = 6;
  localparam int INC_W = 6;
  localparam logic [INC_W-1:0] INC_RST = 6'h00;
  localparam logic OCC_SEL_RST = 1'b0;
endpackage : uqes_pkg

`default_nettype wire

//--- uqes_event_src.sv
// Event source selector for the request tracking queue counters.
// Assumes all event inputs are one-cycle pulses or levels on clock_i.
`timescale 1ns/1ps
`default_nettype none

module uqes_event_src
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] event_num_i,
  input wire logic [7:0] unit_mask_i,
  input wire logic [uqes_pkg::RT_ENTRIES-1:0] read_tracker_valid_i,
  input wire logic read_tracker_alloc_i,
  input wire logic read_llc_miss_i,
  input wire logic read_llc_resp_i,
  input wire logic read_tid_wait_i,
  input wire logic write_tid_wait_i,
  input wire logic write_llc_miss_i,
  input wire logic probe_llc_miss_i,
  input wire logic system_link_in_busy_i,
  input wire logic memory_controller_link_in_busy_i,
  input wire logic llc_input_port_busy_i,
  input wire logic cores02_in_busy_i,
  input wire logic cores13_in_busy_i,
  input wire logic link_output_port_busy_i,
  input wire logic llc_output_port_busy_i,
  input wire logic core_output_port_busy_i,
  input wire logic snoop_resp_absent_i,
  output logic [uqes_pkg::INC_W-1:0] increment_o,
  output logic select_valid_o
);
  import uqes_pkg::*;

  // ----------------------------------------------------------------------
  // Selection decode
  // ----------------------------------------------------------------------
  function automatic logic sel(input logic [7:0] ev, input logic [7:0] um,
                               input logic [7:0] e, input logic [7:0] u);
    sel = (ev == e) && (um == u);
  endfunction

  wire logic s_occ = sel(event_num_i, unit_mask_i, EV_OCCUPANCY, UM_OCC_READ);
  wire logic s_rd_alloc = sel(event_num_i, unit_mask_i, EV_ALLOC, UM_ALLOC_READ);
  wire logic s_rd_miss = sel(event_num_i, unit_mask_i, EV_ALLOC, UM_ALLOC_RD_MISS);
  wire logic s_rd_resp = sel(event_num_i, unit_mask_i, EV_ALLOC, UM_ALLOC_RD_RESP);
  wire logic s_rd_tid = sel(event_num_i, unit_mask_i, EV_ALLOC, UM_ALLOC_RD_TID);
  wire logic s_wr_tid = sel(event_num_i, unit_mask_i, EV_ALLOC, UM_ALLOC_WR_TID);
  wire logic s_wr_miss = sel(event_num_i, unit_mask_i, EV_ALLOC, UM_ALLOC_WR_MISS);
  wire logic s_probe = sel(event_num_i, unit_mask_i, EV_ALLOC, UM_ALLOC_PROBE);
  wire logic s_in_sys = sel(event_num_i, unit_mask_i, EV_DATA_IN, UM_IN_SYSLINK);
  wire logic s_in_mc = sel(event_num_i, unit_mask_i, EV_DATA_IN, UM_IN_MCLINK);
  wire logic s_in_llc = sel(event_num_i, unit_mask_i, EV_DATA_IN, UM_IN_LLC);
  wire logic s_in_c02 = sel(event_num_i, unit_mask_i, EV_DATA_IN, UM_IN_CORES02);
  wire logic s_in_c13 = sel(event_num_i, unit_mask_i, EV_DATA_IN, UM_IN_CORES13);
  wire logic s_out_lnk = sel(event_num_i, unit_mask_i, EV_DATA_OUT, UM_OUT_LINKS);
  wire logic s_out_llc = sel(event_num_i, unit_mask_i, EV_DATA_OUT, UM_OUT_LLC);
  wire logic s_out_cor = sel(event_num_i, unit_mask_i, EV_DATA_OUT, UM_OUT_CORES);
  wire logic s_snp = sel(event_num_i, unit_mask_i, EV_SNP_LOCAL, UM_SNP_ABSENT);

  // ----------------------------------------------------------------------
  // Occupancy population count
  // ----------------------------------------------------------------------
  // A full tracker gives 32, so all six bits are needed
  logic [OCC_W-1:0] occ_count;
  always_comb begin
    occ_count = '0;
    for (int i = 0; i < RT_ENTRIES; i++) begin
      occ_count = occ_count + OCC_W'(read_tracker_valid_i[i]);
    end
  end

  // ----------------------------------------------------------------------
  // Single-bit sources, one hit per cycle at most
  // ----------------------------------------------------------------------
  wire logic one_hit =
      (s_rd_alloc & read_tracker_alloc_i) |
      (s_rd_miss & read_llc_miss_i) |
      (s_rd_resp & read_llc_resp_i) |
      (s_rd_tid & read_tid_wait_i) |
      (s_wr_tid & write_tid_wait_i) |
      (s_wr_miss & write_llc_miss_i) |
      (s_probe & probe_llc_miss_i) |
      (s_in_sys & system_link_in_busy_i) |
      (s_in_mc & memory_controller_link_in_busy_i) |
      (s_in_llc & llc_input_port_busy_i) |
      (s_in_c02 & cores02_in_busy_i) |
      (s_in_c13 & cores13_in_busy_i) |
      (s_out_lnk & link_output_port_busy_i) |
      (s_out_llc & llc_output_port_busy_i) |
      (s_out_cor & core_output_port_busy_i) |
      (s_snp & snoop_resp_absent_i);

  wire logic any_sel = s_occ | s_rd_alloc | s_rd_miss | s_rd_resp | s_rd_tid |
      s_wr_tid | s_wr_miss | s_probe | s_in_sys | s_in_mc | s_in_llc |
      s_in_c02 | s_in_c13 | s_out_lnk | s_out_llc | s_out_cor | s_snp;

  // Unlisted pairs fall through to zero
  wire logic [INC_W-1:0] inc_nxt =
      s_occ ? occ_count :
      (any_sel ? INC_W'(one_hit) : INC_RST);

  // ----------------------------------------------------------------------
  // Registered output; one cycle latency from the event
  // ----------------------------------------------------------------------
  // Costs a cycle, but the counter adder sees a settled value
  logic [INC_W-1:0] inc_r;
  logic sel_r;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      inc_r <= INC_RST;
      sel_r <= OCC_SEL_RST;
    end else begin
      inc_r <= inc_nxt;
      sel_r <= any_sel;
    end
  end
  assign increment_o = inc_r;
  assign select_valid_o = sel_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_occ_sum: assert property (@(posedge clock_i) disable iff (srst_i)
    s_occ |=> increment_o == OCC_W'($countones($past(read_tracker_valid_i))))
    else $error("occupancy increment wrong");
  a_alloc_count: assert property (@(posedge clock_i) disable iff (srst_i)
    s_rd_alloc |=> increment_o == INC_W'($past(read_tracker_alloc_i)))
    else $error("read allocation increment wrong");
  a_rd_miss: assert property (@(posedge clock_i) disable iff (srst_i)
    (s_rd_miss && read_llc_miss_i) |=> increment_o == 6'h01)
    else $error("read miss not counted");
  a_rd_resp: assert property (@(posedge clock_i) disable iff (srst_i)
    (s_rd_resp && !read_llc_resp_i) |=> increment_o == 6'h00)
    else $error("read response counted without event");
  a_rd_tid: assert property (@(posedge clock_i) disable iff (srst_i)
    s_rd_tid |=> increment_o == INC_W'($past(read_tid_wait_i)))
    else $error("read tid wait increment wrong");
  a_wr_tid: assert property (@(posedge clock_i) disable iff (srst_i)
    s_wr_tid |=> increment_o == INC_W'($past(write_tid_wait_i)))
    else $error("write tid wait increment wrong");
  a_wr_miss: assert property (@(posedge clock_i) disable iff (srst_i)
    s_wr_miss |=> increment_o == INC_W'($past(write_llc_miss_i)))
    else $error("write miss increment wrong");
  a_probe_miss: assert property (@(posedge clock_i) disable iff (srst_i)
    s_probe |=> increment_o == INC_W'($past(probe_llc_miss_i)))
    else $error("probe miss increment wrong");
  a_in_links: assert property (@(posedge clock_i) disable iff (srst_i)
    (s_in_sys || s_in_mc) |=> increment_o <= 6'h01)
    else $error("link input increment above one");
  a_llc_in: assert property (@(posedge clock_i) disable iff (srst_i)
    s_in_llc |=> increment_o == INC_W'($past(llc_input_port_busy_i)))
    else $error("llc input increment wrong");
  a_core_in: assert property (@(posedge clock_i) disable iff (srst_i)
    s_in_c13 |=> increment_o == INC_W'($past(cores13_in_busy_i)))
    else $error("core input increment wrong");
  a_link_out: assert property (@(posedge clock_i) disable iff (srst_i)
    s_out_lnk |=> increment_o == INC_W'($past(link_output_port_busy_i)))
    else $error("link output increment wrong");
  a_llc_out: assert property (@(posedge clock_i) disable iff (srst_i)
    s_out_llc |=> increment_o == INC_W'($past(llc_output_port_busy_i)))
    else $error("llc output increment wrong");
  a_core_out: assert property (@(posedge clock_i) disable iff (srst_i)
    s_out_cor |=> increment_o == INC_W'($past(core_output_port_busy_i)))
    else $error("core output increment wrong");
  a_snoop_absent: assert property (@(posedge clock_i) disable iff (srst_i)
    s_snp |=> increment_o == INC_W'($past(snoop_resp_absent_i)))
    else $error("snoop response increment wrong");
  a_unlisted_zero: assert property (@(posedge clock_i) disable iff (srst_i)
    !any_sel |=> (increment_o == 6'h00) && !select_valid_o)
    else $error("unlisted selection gave increment");

  // ----------------------------------------------------------------------
  // Exact counts of the remaining sources, then range, bound and select flag checks
  // ----------------------------------------------------------------------
  a_rd_miss_eq: assert property (@(posedge clock_i) disable iff (srst_i)
    s_rd_miss |=> increment_o == INC_W'($past(read_llc_miss_i)))
    else $error("read miss increment wrong");
  a_rd_resp_eq: assert property (@(posedge clock_i) disable iff (srst_i)
    s_rd_resp |=> increment_o == INC_W'($past(read_llc_resp_i)))
    else $error("read response increment wrong");
  a_sys_link_in: assert property (@(posedge clock_i) disable iff (srst_i)
    s_in_sys |=> increment_o == INC_W'($past(system_link_in_busy_i)))
    else $error("system link input increment wrong");
  a_mc_link_in: assert property (@(posedge clock_i) disable iff (srst_i)
    s_in_mc |=> increment_o == INC_W'($past(memory_controller_link_in_busy_i)))
    else $error("memory controller link input increment wrong");
  a_core02_in: assert property (@(posedge clock_i) disable iff (srst_i)
    s_in_c02 |=> increment_o == INC_W'($past(cores02_in_busy_i)))
    else $error("cores zero and two input increment wrong");
  a_occ_range: assert property (@(posedge clock_i) disable iff (srst_i)
    s_occ |=> increment_o <= 6'h20)
    else $error("occupancy increment above tracker depth");
  a_occ_empty: assert property (@(posedge clock_i) disable iff (srst_i)
    (s_occ && (read_tracker_valid_i == '0)) |=> increment_o == 6'h00)
    else $error("empty tracker gave occupancy");
  a_single_max: assert property (@(posedge clock_i) disable iff (srst_i)
    (any_sel && !s_occ) |=> increment_o <= 6'h01)
    else $error("single source increment above one");
  a_sel_listed: assert property (@(posedge clock_i) disable iff (srst_i)
    any_sel |=> select_valid_o)
    else $error("listed selection not flagged");

endmodule // uqes_event_src

`default_nettype wire

//--- uqes_counter_model.sv
// Counter model standing for the select and accumulate logic.
// Assumes increment and select valid are registered on clock_i.
`timescale 1ns/1ps
`default_nettype none

module uqes_counter_model
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [uqes_pkg::INC_W-1:0] increment_i,
  input wire logic select_valid_i,
  output logic [31:0] count_o
);
  import uqes_pkg::*;

  logic [31:0] count_r;
  logic [31:0] count_nxt;
  // Unselected cycles never add, even if the increment is nonzero
  assign count_nxt = select_valid_i ? count_r + 32'(increment_i) : count_r;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      count_r <= 32'h0000_0000;
    end else begin
      count_r <= count_nxt;
    end
  end
  assign count_o = count_r;
endmodule // uqes_counter_model

`default_nettype wire

//--- test_uncore_queue_event_sources.sv
// Self-checking bench for the queue event source selector.
// Assumes uqes_pkg, the selector and the counter model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_uncore_queue_event_sources;
  import uqes_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] ev = 8'h00;
  logic [7:0] um = 8'h00;
  logic [15:0] src = 16'h0000;
  logic [31:0] valid = 32'h0000_0000;
  logic [INC_W-1:0] inc;
  logic sel;
  logic [31:0] total;
  logic [31:0] expected_total = 32'h0000_0000;
  int failures = 0;
  int checks_done = 0;

  always #12.5 clock_i = ~clock_i;

  uqes_event_src uut (.clock_i(clock_i), .srst_i(srst_i), .event_num_i(ev), .unit_mask_i(um),
    .read_tracker_valid_i(valid), .read_tracker_alloc_i(src[0]), .read_llc_miss_i(src[1]),
    .read_llc_resp_i(src[2]), .read_tid_wait_i(src[3]), .write_tid_wait_i(src[4]),
    .write_llc_miss_i(src[5]), .probe_llc_miss_i(src[6]), .system_link_in_busy_i(src[7]),
    .memory_controller_link_in_busy_i(src[8]), .llc_input_port_busy_i(src[9]),
    .cores02_in_busy_i(src[10]), .cores13_in_busy_i(src[11]),
    .link_output_port_busy_i(src[12]), .llc_output_port_busy_i(src[13]),
    .core_output_port_busy_i(src[14]), .snoop_resp_absent_i(src[15]),
    .increment_o(inc), .select_valid_o(sel));

  uqes_counter_model model (.clock_i(clock_i), .srst_i(srst_i), .increment_i(inc),
    .select_valid_i(sel), .count_o(total));

  // ----------------------------------------------------------------------
  // Compare and stimulus tasks
  // ----------------------------------------------------------------------
  task automatic compare_value(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic compare_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: flag got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Inputs stand for two sampling edges, so the model adds each answer twice
  task automatic step(input logic [7:0] e, input logic [7:0] m, input logic [15:0] s,
                      input logic [31:0] v, input logic [31:0] exp_inc, input logic exp_sel);
    @(posedge clock_i);
    ev <= e;
    um <= m;
    src <= s;
    valid <= v;
    @(posedge clock_i);
    #1;
    compare_value(32'(inc), exp_inc);
    compare_flag(sel, exp_sel);
    if (exp_sel) expected_total += 32'h2 * exp_inc;
  endtask

  // Own source counts; every other source and an off-by-one-bit mask do not
  task automatic check_source(input logic [7:0] e, input logic [7:0] m, input int idx);
    step(e, m, 16'h0001 << idx, 32'h0000_0000, 32'h1, 1'b1);
    step(e, m, ~(16'h0001 << idx), 32'hFFFF_FFFF, 32'h0, 1'b1);
    step(e, m | 8'h80, 16'hFFFF, 32'hFFFF_FFFF, 32'h0, 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    compare_value(32'(inc), 32'h0);
    compare_flag(sel, 1'b0);
  endtask

  task automatic test_occupancy();
    step(EV_OCCUPANCY, UM_OCC_READ, 16'hFFFF, 32'h0000_0007, 32'h3, 1'b1);
    step(EV_OCCUPANCY, UM_OCC_READ, 16'h0000, 32'hFFFF_FFFF, 32'h20, 1'b1);
    step(EV_OCCUPANCY, UM_OCC_READ, 16'hFFFF, 32'h8000_0001, 32'h2, 1'b1);
    step(EV_OCCUPANCY, UM_OCC_READ, 16'hFFFF, 32'h0000_0000, 32'h0, 1'b1);
  endtask

  task automatic test_read_allocs();
    check_source(EV_ALLOC, UM_ALLOC_READ, 0);
    check_source(EV_ALLOC, UM_ALLOC_RD_MISS, 1);
    check_source(EV_ALLOC, UM_ALLOC_RD_RESP, 2);
    check_source(EV_ALLOC, UM_ALLOC_RD_TID, 3);
  endtask

  task automatic test_write_allocs();
    check_source(EV_ALLOC, UM_ALLOC_WR_TID, 4);
    check_source(EV_ALLOC, UM_ALLOC_WR_MISS, 5);
  endtask

  task automatic test_probe_alloc();
    check_source(EV_ALLOC, UM_ALLOC_PROBE, 6);
  endtask

  task automatic test_input_ports();
    check_source(EV_DATA_IN, UM_IN_SYSLINK, 7);
    check_source(EV_DATA_IN, UM_IN_MCLINK, 8);
    check_source(EV_DATA_IN, UM_IN_LLC, 9);
    check_source(EV_DATA_IN, UM_IN_CORES02, 10);
    check_source(EV_DATA_IN, UM_IN_CORES13, 11);
  endtask

  task automatic test_output_ports();
    check_source(EV_DATA_OUT, UM_OUT_LINKS, 12);
    check_source(EV_DATA_OUT, UM_OUT_LLC, 13);
    check_source(EV_DATA_OUT, UM_OUT_CORES, 14);
  endtask

  task automatic test_snoop_resp();
    check_source(EV_SNP_LOCAL, UM_SNP_ABSENT, 15);
  endtask

  task automatic test_unlisted();
    step(8'h07, 8'h01, 16'hFFFF, 32'hFFFF_FFFF, 32'h0, 1'b0);
    step(EV_DATA_IN, 8'h0C, 16'hFFFF, 32'hFFFF_FFFF, 32'h0, 1'b0);
    step(8'h00, 8'h00, 16'h0000, 32'h0000_0000, 32'h0, 1'b0);
  endtask

  // Last selected answer needs two edges to reach the model total
  task automatic test_counter_total();
    repeat (2) @(posedge clock_i);
    #1;
    compare_value(total, expected_total);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    test_reset();
    test_occupancy();
    test_read_allocs();
    test_write_allocs();
    test_probe_alloc();
    test_input_ports();
    test_output_ports();
    test_snoop_resp();
    test_unlisted();
    test_counter_total();
    summarize();
  end

  // Run needs about 120 cycles; this leaves ample margin
  initial begin
    repeat (2000) @(posedge clock_i);
    failures++;
    summarize();
  end
endmodule // test_uncore_queue_event_sources

`default_nettype wire
